// ===== core/gain_interp.v
// Purpose: Interpolate gain factor and scale the tank-loss code
// Assumes: Gain factors in 2.14 fixed point, frac in quarter steps
// Notes:   Purely combinational; result clamped to 16 bits
`timescale 1ns/100ps
`default_nettype none
`include "prox_defines.vh"

module gain_interp
(
  input  wire [15:0] gcf_lo_i,
  input  wire [15:0] gcf_hi_i,
  input  wire [1:0]  frac_i,
  input  wire [15:0] rp_i,
  output reg  [15:0] comp_o
);

  reg signed [16:0] diff;
  reg signed [19:0] step;
  reg signed [17:0] gain_correction_factor;
  reg        [15:0] gcf_u;
  reg        [31:0] prod;
  reg        [17:0] scaled;

  // Linear step between 4 degree points, then scale and clamp
  always @*
  begin
    diff   = $signed({1'b0, gcf_hi_i}) - $signed({1'b0, gcf_lo_i});
    step   = diff * $signed({1'b0, frac_i});
    gain_correction_factor    = $signed({2'b00, gcf_lo_i}) + $signed(step[19:2]);
    gcf_u  = gain_correction_factor[17] ? 16'h0000 : (gain_correction_factor[16] ? 16'hFFFF : gain_correction_factor[15:0]);
    prod   = rp_i * gcf_u;
    scaled = prod[31:`GCF_SHIFT];
    comp_o = (scaled[17:16] != 2'b00) ? 16'hFFFF : scaled[15:0];
  end

endmodule // gain_interp
`default_nettype wire

// ===== core/prox_decision.v
// Purpose: Switch decision, under range, overload and LED control
// Assumes: Converter and temperature inputs share clk_i; short pin async
// Notes:   Byte register port; LUT held in flip-flops
`timescale 1ns/100ps
`default_nettype none
`include "prox_defines.vh"

module prox_decision
#(
  parameter integer SHORT_ON_CYC     = `SHORT_ON_CYC,
  parameter integer SHORT_OFF_LO_CYC = `SHORT_OFF_LO_CYC,
  parameter integer SHORT_OFF_HI_CYC = `SHORT_OFF_HI_CYC,
  parameter integer BLINK_HALF_CYC   = `BLINK_HALF_CYC,
  parameter integer CNT_W            = 27
)
(
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        reg_we_i,
  input  wire [6:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire        conv_valid_i,
  input  wire [15:0] rp_code_i,
  input  wire        under_range_i,
  input  wire        below_lower_i,
  input  wire        temp_valid_i,
  input  wire [5:0]  temp_index_i,
  input  wire [1:0]  temp_frac_i,
  input  wire        short_det_i,
  input  wire        ecc_err_i,
  output reg         switch_drive_output_o,
  output reg         switch_drive_output_weak_pd_o,
  output reg         sw_source_mode_o,
  output reg         led_o,
  output reg         indicator_sink_level_o,
  output reg         too_close_o,
  output reg  [15:0] detector_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam [2:0] ST_NORM = 3'b001;
  localparam [2:0] ST_PON  = 3'b010;
  localparam [2:0] ST_POFF = 3'b100;

  reg [7:0]       lut_mem [0:`LUT_ENTRIES*2-1];
  reg [7:0]       hi_up_r, hi_lo_r;
  reg [7:0]       lo_up_r, lo_lo_r;
  reg [7:0]       cfg_init_r, cfg_final_r;
  reg             final_set_r;
  reg             short_m_r, short_s_r;
  reg             temp_done_r;
  reg [2:0]       conv_cnt_r;
  reg [5:0]       t_idx_r;
  reg [1:0]       t_frac_r;
  reg             sw_state_r, sw_state_nxt;
  reg [2:0]       pstate_r, pstate_nxt;
  reg [CNT_W-1:0] ptmr_r, ptmr_nxt;
  reg [CNT_W-1:0] blink_cnt_r;
  reg             blink_r;
  reg [7:0]       rdata_nxt;
  wire [7:0]      cfg;
  wire [15:0]     hi_thr, lo_thr;
  wire [5:0]      idx_hi;
  wire [15:0]     comp_val;
  wire [15:0]     det_val;
  wire [CNT_W-1:0] off_cyc;
  integer         i;

  // Fetch one two-byte table entry
  function [15:0] lut_entry;
    input [5:0] idx;
    begin
      lut_entry = {lut_mem[{idx, 1'b0}], lut_mem[{idx, 1'b1}]};
    end
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Final config takes over once written
  assign cfg    = final_set_r ? cfg_final_r : cfg_init_r;
  assign hi_thr = {hi_up_r, hi_lo_r};
  assign lo_thr = {lo_up_r, lo_lo_r};

  // Register writes
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (i = 0; i < `LUT_ENTRIES; i = i + 1)
      begin
        {lut_mem[2*i], lut_mem[2*i+1]} <= `GCF_UNITY;
      end
      {hi_up_r, hi_lo_r} <= `HI_THR_RESET;
      {lo_up_r, lo_lo_r} <= `LO_THR_RESET;
      cfg_init_r  <= `OUT_CFG_RESET;
      cfg_final_r <= `OUT_CFG_RESET;
      final_set_r <= 1'b0;
    end
    else if (reg_we_i)
    begin
      if (reg_addr_i <= `LUT_LAST)
        lut_mem[reg_addr_i] <= reg_wdata_i;
      case (reg_addr_i)
        `HI_THR_UPPER:  hi_up_r <= reg_wdata_i;
        `HI_THR_LOWER:  hi_lo_r <= reg_wdata_i;
        `LO_THR_UPPER:  lo_up_r <= reg_wdata_i;
        `LO_THR_LOWER:  lo_lo_r <= reg_wdata_i;
        `OUT_CFG_INIT:  cfg_init_r <= reg_wdata_i;
        `OUT_CFG_FINAL:
        begin
          cfg_final_r <= reg_wdata_i;
          final_set_r <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Read mux
  always @*
  begin
    rdata_nxt = 8'h00;
    if (reg_addr_i <= `LUT_LAST)
      rdata_nxt = lut_mem[reg_addr_i];
    else
    begin
      case (reg_addr_i)
        `HI_THR_UPPER:  rdata_nxt = hi_up_r;
        `HI_THR_LOWER:  rdata_nxt = hi_lo_r;
        `LO_THR_UPPER:  rdata_nxt = lo_up_r;
        `LO_THR_LOWER:  rdata_nxt = lo_lo_r;
        `PROX_UPPER:    rdata_nxt = detector_o[15:8];
        `PROX_LOWER:    rdata_nxt = detector_o[7:0];
        `OUT_CFG_INIT:  rdata_nxt = cfg_init_r;
        `OUT_CFG_FINAL: rdata_nxt = cfg_final_r;
        `STATE_REG:     rdata_nxt = {1'b0, conv_cnt_r, temp_done_r, too_close_o,
                                     ~pstate_r[0], sw_state_r};
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  // Registered read data
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= rdata_nxt;
  end

  // ----------------------------------------
  // Input capture
  // ----------------------------------------
  // Short level from the sense comparator pin
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      {short_s_r, short_m_r} <= 2'b00;
    else
      {short_s_r, short_m_r} <= {short_m_r, short_det_i};
  end

  // Temperature point and conversion bookkeeping
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      temp_done_r <= 1'b0;
      t_idx_r     <= 6'h00;
      t_frac_r    <= 2'h0;
      conv_cnt_r  <= 3'h0;
    end
    else
    begin
      if (temp_valid_i)
      begin
        temp_done_r <= 1'b1;
        t_idx_r     <= (temp_index_i > 6'd46) ? 6'd46 : temp_index_i;
        t_frac_r    <= temp_frac_i;
      end
      if (conv_valid_i && conv_cnt_r != 3'h4)
        conv_cnt_r <= conv_cnt_r + 3'h1;
    end
  end

  // ----------------------------------------
  // Compensation
  // ----------------------------------------
  assign idx_hi = (t_idx_r == 6'd46) ? t_idx_r : t_idx_r + 6'h01;

  gain_interp u_gain_interp
  (
    .gcf_lo_i (lut_entry(t_idx_r)),
    .gcf_hi_i (lut_entry(idx_hi)),
    .frac_i   (t_frac_r),
    .rp_i     (rp_code_i),
    .comp_o   (comp_val)
  );

  // Railed when the tank is below its lower limit
  assign det_val = below_lower_i ? 16'h0000 : comp_val;

  // ----------------------------------------
  // Switch decision
  // ----------------------------------------
  // Comparator with hysteresis and under range handling
  always @*
  begin
    sw_state_nxt = sw_state_r;
    if (conv_valid_i && temp_done_r)
    begin
      if (under_range_i)
      begin
        if (conv_cnt_r < `EARLY_CONV_LIMIT)
          sw_state_nxt = 1'b1;
        else if (cfg[`CFG_UR_EN_BIT])
          sw_state_nxt = 1'b1;
        else
          sw_state_nxt = sw_state_r;
      end
      else if (!sw_state_r && det_val <= hi_thr)
        sw_state_nxt = 1'b1;
      else if (sw_state_r && det_val >= lo_thr)
        sw_state_nxt = 1'b0;
    end
  end

  // Decision state and detector readback
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sw_state_r  <= 1'b0;
      detector_o  <= 16'h0000;
      too_close_o <= 1'b0;
    end
    else
    begin
      sw_state_r <= sw_state_nxt;
      if (conv_valid_i)
      begin
        detector_o  <= det_val;
        too_close_o <= below_lower_i;
      end
    end
  end

  // ----------------------------------------
  // Overload protection
  // ----------------------------------------
  assign off_cyc = cfg[`CFG_DUTY_BIT] ? SHORT_OFF_HI_CYC[CNT_W-1:0]
                                      : SHORT_OFF_LO_CYC[CNT_W-1:0];

  // On/off toggling while the short persists
  always @*
  begin
    pstate_nxt = pstate_r;
    ptmr_nxt   = ptmr_r;
    case (pstate_r)
      ST_NORM:
      begin
        if (sw_state_r && short_s_r)
        begin
          pstate_nxt = ST_PON;
          ptmr_nxt   = SHORT_ON_CYC[CNT_W-1:0] - 1'b1;
        end
      end
      ST_PON:
      begin
        if (ptmr_r != {CNT_W{1'b0}})
          ptmr_nxt = ptmr_r - 1'b1;
        else if (short_s_r)
        begin
          pstate_nxt = ST_POFF;
          ptmr_nxt   = off_cyc - 1'b1;
        end
        else
          pstate_nxt = ST_NORM;
      end
      ST_POFF:
      begin
        if (ptmr_r != {CNT_W{1'b0}})
          ptmr_nxt = ptmr_r - 1'b1;
        else if (!sw_state_r)
          pstate_nxt = ST_NORM;
        else
        begin
          pstate_nxt = ST_PON;
          ptmr_nxt   = SHORT_ON_CYC[CNT_W-1:0] - 1'b1;
        end
      end
      default:
      begin
        pstate_nxt = ST_NORM;
        ptmr_nxt   = {CNT_W{1'b0}};
      end
    endcase
  end

  // Protection state
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      {pstate_r, ptmr_r} <= {ST_NORM, {CNT_W{1'b0}}};
    else
      {pstate_r, ptmr_r} <= {pstate_nxt, ptmr_nxt};
  end

  // ----------------------------------------
  // LED blink timebase
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      blink_cnt_r <= {CNT_W{1'b0}};
      blink_r     <= 1'b0;
    end
    else if (blink_cnt_r == BLINK_HALF_CYC[CNT_W-1:0] - 1'b1)
    begin
      blink_cnt_r <= {CNT_W{1'b0}};
      blink_r     <= ~blink_r;
    end
    else
      blink_cnt_r <= blink_cnt_r + 1'b1;
  end

  // ----------------------------------------
  // Output drivers
  // ----------------------------------------
  // Registered pin controls
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      switch_drive_output_o                <= 1'b0;
      switch_drive_output_weak_pd_o        <= 1'b1;
      sw_source_mode_o       <= 1'b0;
      led_o                  <= 1'b0;
      indicator_sink_level_o <= 1'b0;
    end
    else
    begin
      switch_drive_output_weak_pd_o        <= ~temp_done_r;
      sw_source_mode_o       <= cfg[`CFG_SOURCE_BIT];
      indicator_sink_level_o <= cfg[`CFG_LED_SINK_BIT];
      if (!temp_done_r)
        switch_drive_output_o <= 1'b0;
      else if (pstate_r == ST_NORM)
        switch_drive_output_o <= sw_state_r;
      else
        switch_drive_output_o <= pstate_r[1];
      if (pstate_r != ST_NORM || ecc_err_i)
        led_o <= blink_r;
      else
        led_o <= sw_state_r ^ cfg[`CFG_LED_INV_BIT];
    end
  end

endmodule // prox_decision
`default_nettype wire

// ===== core/prox_defines.vh
// Purpose: Constants for the proximity switch decision logic
// Assumes: 200 MHz system clock, byte-wide register port
// Notes:   Offsets, field positions, reset values and timing counts
//
// What this block does
// - Compensated value compared against high threshold
// - Low threshold gives hysteresis release point
// - Lookup table correction stored at 0x00-0x5D
// - Two-byte entries, 4 degree points, interpolated
// - Under range before fourth conversion closes switch
// - Later under range with enable closes switch
// - Later under range without enable holds state
// - No under range action before temperature conversion
// - Below lower limit flags too close, rails output
// - Persistent short toggles switch instead of closed
// - Short toggling: 30 us on, off from ratio
// - Duty selection from bit 0 of config
// - Duty bit 0 gives 0.1%, 1 gives 0.8%
// - Short level gone, resume normal switching
// - LED follows switch, polarity selectable
// - LED also signals overload or ECC error
// - LED blinks at 2 Hz for faults
// - LED sink current level selectable
// - Switch drive weakly pulled low during power up
// - Switch drive selectable sinking or sourcing
`ifndef PROX_DEFINES_VH
`define PROX_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LUT_FIRST        7'h00
`define LUT_LAST         7'h5D
`define LUT_ENTRIES      47
`define HI_THR_UPPER     7'h6A
`define HI_THR_LOWER     7'h6B
`define LO_THR_UPPER     7'h6C
`define LO_THR_LOWER     7'h6D
`define PROX_UPPER       7'h6E
`define PROX_LOWER       7'h6F
`define OUT_CFG_INIT     7'h72
`define OUT_CFG_FINAL    7'h78
`define STATE_REG        7'h7E

// ----------------------------------------
// Output configuration fields
// ----------------------------------------
`define CFG_DUTY_BIT     0
`define CFG_LED_INV_BIT  1
`define CFG_LED_SINK_BIT 2
`define CFG_SOURCE_BIT   3
`define CFG_UR_EN_BIT    4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GCF_UNITY        16'h4000
`define GCF_SHIFT        14
`define HI_THR_RESET     16'h4000
`define LO_THR_RESET     16'h5000
`define OUT_CFG_RESET    8'h00
`define EARLY_CONV_LIMIT 3'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS    5
`define SHORT_ON_NS      30000
`define DUTY_LO_DIV      1000
`define DUTY_HI_DIV      125
`define BLINK_RATE_HZ    2
`define SHORT_ON_CYC     (`SHORT_ON_NS / `CLK_PERIOD_NS)
`define SHORT_OFF_LO_CYC ((`SHORT_ON_NS * `DUTY_LO_DIV - `SHORT_ON_NS) / `CLK_PERIOD_NS)
`define SHORT_OFF_HI_CYC ((`SHORT_ON_NS * `DUTY_HI_DIV - `SHORT_ON_NS) / `CLK_PERIOD_NS)
`define BLINK_HALF_CYC   (1000000000 / (2 * `BLINK_RATE_HZ) / `CLK_PERIOD_NS)

`endif

// ===== verif/prox_decision_sva.sv
// Purpose: Port-level checks for prox_decision
// Assumes: Bound to every prox_decision instance, one clock domain
// Notes:   Synchronous reset disables every property
`timescale 1ns/100ps
`default_nettype none
module prox_decision_sva
#(
  parameter integer BLINK_HALF_CYC = 8
)
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        reg_we_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic [7:0]  reg_rdata_o,
  input  wire logic        conv_valid_i,
  input  wire logic        below_lower_i,
  input  wire logic        temp_valid_i,
  input  wire logic        short_det_i,
  input  wire logic        ecc_err_i,
  input  wire logic        switch_drive_output_o,
  input  wire logic        switch_drive_output_weak_pd_o,
  input  wire logic        sw_source_mode_o,
  input  wire logic        led_o,
  input  wire logic        indicator_sink_level_o,
  input  wire logic        too_close_o,
  input  wire logic [15:0] detector_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic       led_q_r;
  logic [7:0] led_run_r;
  // Length of an unchanged LED run while the error flag stands
  always_ff @(posedge clk_i)
  begin
    led_q_r <= led_o;
    if (sys_rst_i || !ecc_err_i || (led_o != led_q_r))
      led_run_r <= 8'h00;
    else if (led_run_r != 8'hFF)
      led_run_r <= led_run_r + 8'h01;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_rail_on_lower: assert property (
    conv_valid_i && below_lower_i |=> detector_o == 16'h0000 && too_close_o)
    else $error("detector not railed below lower limit");
  a_close_flag_clear: assert property (
    conv_valid_i && !below_lower_i |=> !too_close_o)
    else $error("too close flag left set");
  a_detector_holds: assert property (
    !conv_valid_i |=> $stable(detector_o))
    else $error("detector changed without conversion");
  a_no_early_drive: assert property (
    switch_drive_output_weak_pd_o |-> !switch_drive_output_o)
    else $error("switch driven while pull-down active");
  a_pd_release: assert property (
    $fell(switch_drive_output_weak_pd_o) |-> $past(temp_valid_i, 1) || $past(temp_valid_i, 2))
    else $error("pull-down released without temperature conversion");
  a_thr_readback: assert property (
    (reg_we_i && reg_addr_i == 7'h6A) ##1 (!reg_we_i && reg_addr_i == 7'h6A)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("threshold byte readback wrong");
  a_source_cfg: assert property (
    $changed(sw_source_mode_o) |-> $past(reg_we_i, 1) || $past(reg_we_i, 2))
    else $error("drive topology changed without write");
  a_sink_cfg: assert property (
    $changed(indicator_sink_level_o) |-> $past(reg_we_i, 1) || $past(reg_we_i, 2))
    else $error("Indicator_sink_level level changed without write");
  a_short_on_time: assert property (
    $rose(switch_drive_output_o) ##1 short_det_i |-> switch_drive_output_o [*5])
    else $error("short on-phase too short");
  a_short_off_time: assert property (
    $fell(switch_drive_output_o) && short_det_i |-> !switch_drive_output_o [*8])
    else $error("short off-phase too short");
  a_led_blinks: assert property (
    led_run_r < 2 * BLINK_HALF_CYC + 2)
    else $error("LED not blinking on error");
endmodule // prox_decision_sva

bind prox_decision prox_decision_sva #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_sva
(
  .clk_i, .sys_rst_i, .reg_we_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .conv_valid_i,
  .below_lower_i, .temp_valid_i, .short_det_i, .ecc_err_i, .switch_drive_output_o, .switch_drive_output_weak_pd_o,
  .sw_source_mode_o, .led_o, .indicator_sink_level_o, .too_close_o, .detector_o
);
`default_nettype wire

// ===== verif/prox_load_model.sv
// Purpose: External switching transistor with a shortable load
// Assumes: Drive high means the switch conducts
// Notes:   Sense level only rises while current actually flows
`timescale 1ns/100ps
`default_nettype none
module prox_load_model
(
  input  wire logic clk_i,
  input  wire logic drive_i,
  input  wire logic fault_i,
  output var  logic sense_hi_o
);
  initial sense_hi_o = 1'b0;
  // Shorted load trips the sense level only while conducting
  always @(posedge clk_i)
    sense_hi_o <= fault_i & drive_i;
endmodule // prox_load_model
`default_nettype wire

// ===== verif/proximity_switch_decision_test.sv
// Purpose: Self-checking bench for prox_decision
// Assumes: Shortened protection and blink counts
// Notes:   Reference model tracks registers, table and switch state
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module proximity_switch_decision_test;
  // ----------------------------------------
  // Signals and reference state
  // ----------------------------------------
  logic        clk, rst = 1'b1, we = 1'b0, cv = 1'b0, ur = 1'b0, bl = 1'b0;
  logic        tv = 1'b0, ecc = 1'b0, flt = 1'b0;
  logic [6:0]  adr = 7'h00;
  logic [7:0]  wd = 8'h00, cfg;
  logic [15:0] rp = 16'h0000, mhi, mlo, lf = 16'h0011;
  logic [5:0]  ti = 6'h00;
  logic [1:0]  tf = 2'h0;
  logic [15:0] lut [0:47];
  logic        f78, mtmp, msw;
  int          mcnt, mti, mtf, miscompares = 0, samples_checked = 0;
  wire logic [7:0]  rd;
  wire logic [15:0] det;
  wire logic        sw, pd, src, led, snk, tc, sdet;

  prox_decision
  #(
    .SHORT_ON_CYC(6), .SHORT_OFF_LO_CYC(20), .SHORT_OFF_HI_CYC(10), .BLINK_HALF_CYC(8),
    .CNT_W(27)
  )
  DUT
  (
    .clk_i(clk), .sys_rst_i(rst), .reg_we_i(we), .reg_addr_i(adr), .reg_wdata_i(wd),
    .reg_rdata_o(rd), .conv_valid_i(cv), .rp_code_i(rp), .under_range_i(ur),
    .below_lower_i(bl), .temp_valid_i(tv), .temp_index_i(ti), .temp_frac_i(tf),
    .short_det_i(sdet), .ecc_err_i(ecc), .switch_drive_output_o(sw), .switch_drive_output_weak_pd_o(pd),
    .sw_source_mode_o(src), .led_o(led), .indicator_sink_level_o(snk), .too_close_o(tc),
    .detector_o(det)
  );
  prox_load_model LOAD (.clk_i(clk), .drive_i(sw), .fault_i(flt), .sense_hi_o(sdet));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Interpolated gain applied to a raw code
  function automatic int comp(input int r);
    int g;
    g = int'(lut[mti]) + (((int'(lut[mti + 1]) - int'(lut[mti])) * mtf) >>> 2);
    comp = (r * g) >>> 14;
    if (comp > 65535)
      comp = 65535;
  endfunction
  task automatic rst_seq;
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (lut[i])
      lut[i] = 16'h4000;
    mhi = 16'h4000;
    mlo = 16'h5000;
    cfg = 8'h00;
    {f78, mtmp, msw, mcnt, mti, mtf} = '0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
    case (a)
      7'h6A: mhi[15:8] = d;
      7'h6B: mhi[7:0] = d;
      7'h6C: mlo[15:8] = d;
      7'h6D: mlo[7:0] = d;
      7'h72: if (!f78) cfg = d;
      7'h78: {f78, cfg} = {1'b1, d};
      default: if (a < 7'h5E && a[0]) lut[a >> 1][7:0] = d;
               else if (a < 7'h5E) lut[a >> 1][15:8] = d;
    endcase
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    wr(a + 7'h01, d[7:0]);
    wr(a, d[15:8]);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    adr <= a;
    repeat (2) @(posedge clk);
    #1 `CHK(rd, e)
  endtask
  task automatic tmp(input int i, input int f);
    @(posedge clk);
    {tv, ti, tf} <= {1'b1, i[5:0], f[1:0]};
    @(posedge clk);
    tv <= 1'b0;
    {mtmp, mti, mtf} = {1'b1, i, f};
  endtask
  // One conversion, then model update and comparison of detector (outside under range), flag, switch and LED
  task automatic cnv(input logic [15:0] r, input logic u, input logic b);
    int v;
    @(posedge clk);
    {cv, rp, ur, bl} <= {1'b1, r, u, b};
    @(posedge clk);
    cv <= 1'b0;
    v = b ? 0 : comp(r);
    if (mtmp && u && (mcnt < 3 || cfg[4])) msw = 1'b1;
    else if (mtmp && !u && v <= mhi) msw = 1'b1;
    else if (mtmp && !u && v >= mlo) msw = 1'b0;
    mcnt++;
    repeat (2) @(posedge clk);
    #1;
    if (!u) `CHK(det, v[15:0])
    `CHK(tc, b)
    `CHK(sw, msw)
    `CHK(led, msw ^ cfg[1])
  endtask
  task automatic meas(input logic lv, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (sw === lv && n < 2000);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int   n;
    logic lp;
    rst_seq;
    rdc(7'h78, 8'h00);
    wr(7'h70, 8'hA5);
    rdc(7'h70, 8'h00);
    cnv(16'h1000, 1'b0, 1'b0);
    `CHK(pd, 1'b1)
    rdc(7'h7E, 8'h10);
    $display("test early_state complete");
    rst_seq;
    tmp(0, 0);
    cnv(16'h6000, 1'b0, 1'b0);
    cnv(16'h1000, 1'b1, 1'b0);
    cnv(16'h6000, 1'b0, 1'b0);
    cnv(16'h1000, 1'b1, 1'b0);
    wr(7'h72, 8'h10);
    cnv(16'h1000, 1'b1, 1'b0);
    `CHK(pd, 1'b0)
    $display("test under_range complete");
    wr16(7'h6A, 16'h3000);
    wr16(7'h6C, 16'h3800);
    rdc(7'h6A, 8'h30);
    rdc(7'h6C, 8'h38);
    for (int i = 0; i < 24; i++)
    begin
      lf = lfsr(lf);
      cnv(16'h2400 + {3'h0, lf[12:0]}, 1'b0, i == 5);
    end
    $display("test hysteresis complete");
    wr16(7'h00, 16'h8000);
    tmp(0, 2);
    cnv(16'h1000, 1'b0, 1'b0);
    wr16(7'h5C, 16'h2000);
    tmp(46, 0);
    cnv(16'h5000, 1'b0, 1'b0);
    rdc(7'h6E, 8'h28);
    rdc(7'h6F, 8'h00);
    rdc(7'h7E, 8'h49);
    $display("test lookup complete");
    wr(7'h72, 8'h0E);
    repeat (3) @(posedge clk);
    #1 `CHK(src, 1'b1)
    `CHK(snk, 1'b1)
    `CHK(led, ~msw)
    @(posedge clk);
    ecc <= 1'b1;
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1 n += int'(led !== lp);
      lp = led;
    end
    `CHK(n >= 3, 1'b1)
    @(posedge clk);
    ecc <= 1'b0;
    wr(7'h72, 8'h00);
    $display("test indication complete");
    // Shorted load with both on ratios, then recovery
    for (int d = 0; d < 2; d++)
    begin
      wr(d ? 7'h78 : 7'h72, d[7:0]);
      @(posedge clk);
      flt <= 1'b1;
      meas(1'b1, n);
      meas(1'b0, n);
      `CHK(n, d ? 10 : 20)
      meas(1'b1, n);
      `CHK(n, 6)
      @(posedge clk);
      flt <= 1'b0;
      repeat (40) @(posedge clk);
      #1 `CHK(sw, 1'b1)
    end
    $display("test overload complete");
    results;
  end
  // Watchdog: the sequence needs well under 4,000 cycles
  initial
  begin
    #200000;
    miscompares++;
    results;
  end
endmodule // proximity_switch_decision_test
`default_nettype wire
